// ### imp_pkg.sv
// Constants for the interrupt mask, poll and end-of-interrupt block
package imp_pkg;
  localparam int APB_AW = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int NUM_SLOT = 11;
  localparam int NUM_CTL = 5;
  localparam int NUM_TMR = 3;
  localparam int NUM_EXT = 5;
  localparam int PRIO_W = 3;
  localparam int TYPE_W = 5;
  localparam int IDX_W = 6;
  // Register indexes, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_VEC = 6'h20;
  localparam logic [IDX_W-1:0] IDX_EOI = 6'h22;
  localparam logic [IDX_W-1:0] IDX_POLL = 6'h24;
  localparam logic [IDX_W-1:0] IDX_POLL_MIRROR = 6'h26;
  localparam logic [IDX_W-1:0] IDX_MASK = 6'h28;
  localparam logic [IDX_W-1:0] IDX_THR = 6'h2a;
  localparam logic [IDX_W-1:0] IDX_ISR = 6'h2c;
  localparam logic [IDX_W-1:0] IDX_REQ = 6'h2e;
  localparam logic [IDX_W-1:0] IDX_STS = 6'h30;
  localparam logic [IDX_W-1:0] IDX_T0 = 6'h32;
  localparam logic [IDX_W-1:0] IDX_D0 = 6'h34;
  localparam logic [IDX_W-1:0] IDX_D1 = 6'h36;
  localparam logic [IDX_W-1:0] IDX_T1 = 6'h38;
  localparam logic [IDX_W-1:0] IDX_T2 = 6'h3a;
  // Reset values and priority limits
  localparam logic [REG_W-1:0] RST_MASK = 16'h07fd;
  localparam logic [PRIO_W-1:0] PRIO_LOW = 3'h7;
  localparam logic [PRIO_W-1:0] RST_THR = 3'h7;
  localparam logic [PRIO_W:0] PRIO_NONE = 4'h8;
  // Implemented slots per mode
  localparam logic [NUM_SLOT-1:0] MST_VALID = 11'h7fd;
  localparam logic [NUM_SLOT-1:0] SLV_VALID = 11'h03d;
  // Field positions
  localparam int BIT_PEND = 15;
  localparam int BIT_NONSPECIFIC_SELECT = 15;
  localparam int BIT_HALT = 15;
  localparam int CTL_MSK_BIT = 3;
  localparam int VEC_LSB = 3;
  localparam int VEC_MSB = 7;
  // Slot numbers, equal to combined mask bit positions
  localparam int SLOT_TMR = 0;
  localparam int SLOT_D0 = 2;
  localparam int SLOT_D1 = 3;
  localparam int SLOT_EXT = 4;
  localparam int SLOT_T1 = 4;
  localparam int SLOT_T2 = 5;
  localparam int SLOT_WD = 9;
  localparam int SLOT_SP = 10;
  // Control register index and slot per control word
  localparam logic [NUM_CTL-1:0][IDX_W-1:0] CTL_IDX = {IDX_T2, IDX_T1, IDX_D1, IDX_D0, IDX_T0};
  localparam logic [NUM_CTL-1:0][3:0] CTL_SLOT = {4'h5, 4'h4, 4'h3, 4'h2, 4'h0};
  // Master mode type per slot
  localparam logic [NUM_SLOT-1:0][TYPE_W-1:0] MST_TYPE = {5'h14, 5'h11, 5'h10, 5'h0f,
    5'h0e, 5'h0d, 5'h0c, 5'h0b, 5'h0a, 5'h09, 5'h08};
  // Slave mode low type bits per slot
  localparam logic [NUM_SLOT-1:0][PRIO_W-1:0] SLV_LOW = {3'h0, 3'h0, 3'h0, 3'h0, 3'h0,
    3'h5, 3'h4, 3'h3, 3'h2, 3'h0, 3'h0};
endpackage

// ### imp_ctrl.sv
// Interrupt controller registers: mask, poll, end-of-interrupt and slave mode
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module imp_ctrl (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [imp_pkg::APB_AW-1:0] paddr_i,
  input wire logic [imp_pkg::DATA_W-1:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [imp_pkg::DATA_W-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Mode select from relocation register
  input wire logic slave_mode_i,
  // Interrupt sources
  input wire logic [imp_pkg::NUM_TMR-1:0] timer_req_i,
  input wire logic [1:0] dma_req_i,
  input wire logic [imp_pkg::NUM_EXT-1:0] ext_int_i,
  input wire logic wd_req_i,
  input wire logic serial_req_i,
  input wire logic nmi_i,
  input wire logic iret_i,
  // CPU side
  input wire logic inta_i,
  output logic int_req_o,
  output logic [7:0] int_type_o,
  output logic dma_halt_o
);
  import imp_pkg::*;

  typedef struct packed {
    logic [NUM_SLOT-1:0] mask;
    logic [NUM_CTL-1:0][PRIO_W-1:0] prio;
    logic [PRIO_W-1:0] thr;
    logic [TYPE_W-1:0] vbase;
    logic [NUM_SLOT-1:0] req;
    logic [NUM_TMR-1:0] tpend;
    logic halt;
    logic [NUM_SLOT-1:0] isr;
    logic [NUM_EXT-1:0] sync1;
    logic [NUM_EXT-1:0] sync2;
    logic [DATA_W-1:0] rdata;
    logic err;
    logic poll_hit;
    logic [3:0] poll_slot;
    logic irq;
    logic [7:0] itype;
  } imp_state_type;

  localparam imp_state_type ST_RESET = '{
    mask: RST_MASK[NUM_SLOT-1:0],
    prio: {NUM_CTL{PRIO_LOW}},
    thr: RST_THR,
    default: '0
  };

  imp_state_type cur_ff;
  imp_state_type nxt_st;

  logic setup;
  logic access;
  logic [IDX_W-1:0] idx;
  logic mapped;
  logic [NUM_SLOT-1:0] valid_m;
  logic [NUM_SLOT-1:0] eff_req;
  logic [NUM_SLOT-1:0][PRIO_W-1:0] prio_of;
  logic [PRIO_W:0] min_isp;
  logic [3:0] top_slot;
  logic top_valid;
  logic [PRIO_W:0] best;
  logic win_valid;
  logic [3:0] win_slot;
  logic [7:0] win_type;
  logic [REG_W-1:0] rd_val;
  logic [REG_W-1:0] wval;
  logic ack;
  logic [3:0] ack_slot;
  logic tmr_done;

  function automatic logic [REG_W-1:0] merge16(input logic [REG_W-1:0] old,
                                              input logic [DATA_W-1:0] d,
                                              input logic [3:0] s);
    logic [REG_W-1:0] m;
    m = {{8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (d[REG_W-1:0] & m);
  endfunction

  assign setup = psel_i & ~penable_i;
  assign access = psel_i & penable_i;
  assign idx = paddr_i[APB_AW-1:2];
  assign pready_o = access;
  assign pslverr_o = access & cur_ff.err;
  assign prdata_o = cur_ff.rdata;
  assign int_req_o = cur_ff.irq;
  assign int_type_o = cur_ff.itype;
  assign dma_halt_o = cur_ff.halt;

  // Request view, priority resolution and read mux
  always_comb begin
    valid_m = slave_mode_i ? SLV_VALID : MST_VALID;
    // Pending view per mode
    eff_req = '0;
    eff_req[SLOT_D0] = cur_ff.req[SLOT_D0];
    eff_req[SLOT_D1] = cur_ff.req[SLOT_D1];
    if (slave_mode_i) begin
      eff_req[SLOT_TMR] = cur_ff.tpend[0];
      eff_req[SLOT_T1] = cur_ff.tpend[1];
      eff_req[SLOT_T2] = cur_ff.tpend[2];
    end else begin
      eff_req[SLOT_TMR] = |cur_ff.tpend;
      eff_req[SLOT_EXT +: NUM_EXT] = cur_ff.sync2;
      eff_req[SLOT_WD] = cur_ff.req[SLOT_WD];
      eff_req[SLOT_SP] = cur_ff.req[SLOT_SP];
    end
    // Master-only sources keep the lowest priority
    for (int i = 0; i < NUM_SLOT; i++) begin
      prio_of[i] = PRIO_LOW;
    end
    prio_of[SLOT_TMR] = cur_ff.prio[0];
    prio_of[SLOT_D0] = cur_ff.prio[1];
    prio_of[SLOT_D1] = cur_ff.prio[2];
    if (slave_mode_i) begin
      prio_of[SLOT_T1] = cur_ff.prio[3];
      prio_of[SLOT_T2] = cur_ff.prio[4];
    end
    // Highest priority source in service
    min_isp = PRIO_NONE;
    top_slot = '0;
    top_valid = 1'b0;
    for (int i = 0; i < NUM_SLOT; i++) begin
      if (cur_ff.isr[i] && valid_m[i] && ({1'b0, prio_of[i]} < min_isp)) begin
        min_isp = {1'b0, prio_of[i]};
        top_slot = 4'(i);
        top_valid = 1'b1;
      end
    end
    // Winner among eligible pending sources
    best = PRIO_NONE;
    win_valid = 1'b0;
    win_slot = '0;
    for (int i = 0; i < NUM_SLOT; i++) begin
      if (eff_req[i] && valid_m[i] && !cur_ff.mask[i] && !cur_ff.isr[i] &&
          (prio_of[i] <= cur_ff.thr) &&
          ({1'b0, prio_of[i]} <= min_isp) &&
          ({1'b0, prio_of[i]} < best)) begin
        best = {1'b0, prio_of[i]};
        win_slot = 4'(i);
        win_valid = 1'b1;
      end
    end
    if (slave_mode_i) begin
      win_type = {cur_ff.vbase, SLV_LOW[win_slot]};
    end else begin
      win_type = {3'h0, MST_TYPE[win_slot]};
    end
    // Address decode
    mapped = 1'b0;
    if (paddr_i[1:0] == 2'h0) begin
      case (idx)
        IDX_VEC, IDX_EOI, IDX_MASK, IDX_THR, IDX_ISR, IDX_REQ, IDX_STS,
        IDX_T0, IDX_D0, IDX_D1: begin
          mapped = 1'b1;
        end
        IDX_POLL, IDX_POLL_MIRROR: begin
          mapped = ~slave_mode_i;
        end
        IDX_T1, IDX_T2: begin
          mapped = slave_mode_i;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
    end
    // Read values; END_OF_INTERRUPT_COMMAND reads as zero
    rd_val = '0;
    case (idx)
      IDX_VEC: begin
        rd_val[VEC_MSB:VEC_LSB] = cur_ff.vbase;
      end
      IDX_POLL, IDX_POLL_MIRROR: begin
        rd_val[BIT_PEND] = win_valid;
        rd_val[TYPE_W-1:0] = win_valid ? win_type[TYPE_W-1:0] : '0;
      end
      IDX_MASK: begin
        rd_val[NUM_SLOT-1:0] = cur_ff.mask & valid_m;
      end
      IDX_THR: begin
        rd_val[PRIO_W-1:0] = cur_ff.thr;
      end
      IDX_ISR: begin
        rd_val[NUM_SLOT-1:0] = cur_ff.isr & valid_m;
      end
      IDX_REQ: begin
        rd_val[NUM_SLOT-1:0] = eff_req & valid_m;
      end
      IDX_STS: begin
        rd_val[BIT_HALT] = cur_ff.halt;
        rd_val[NUM_TMR-1:0] = cur_ff.tpend;
      end
      default: begin
        for (int k = 0; k < NUM_CTL; k++) begin
          if (idx == CTL_IDX[k]) begin
            rd_val[CTL_MSK_BIT] = cur_ff.mask[CTL_SLOT[k]];
            rd_val[PRIO_W-1:0] = cur_ff.prio[k];
          end
        end
      end
    endcase
    // Byte-lane merge for writes
    wval = merge16(rd_val, pwdata_i, pstrb_i);
  end

  // Next state
  always_comb begin
    nxt_st = cur_ff;
    ack = 1'b0;
    ack_slot = win_slot;
    tmr_done = 1'b0;
    // Two-stage synchroniser for external levels
    nxt_st.sync1 = ext_int_i;
    nxt_st.sync2 = cur_ff.sync1;
    // Registered request and type
    nxt_st.irq = win_valid;
    nxt_st.itype = win_type;
    // Read data captured in the setup cycle; unmapped reads return zero
    if (setup) begin
      if (mapped) begin
        nxt_st.rdata = {{(DATA_W-REG_W){1'b0}}, rd_val};
      end else begin
        nxt_st.rdata = '0;
      end
      nxt_st.err = ~mapped;
      nxt_st.poll_hit = mapped & ~pwrite_i & (idx == IDX_POLL) & win_valid;
      nxt_st.poll_slot = win_slot;
    end
    // Register writes; request and in-service are read-only
    if (access && !cur_ff.err && pwrite_i) begin
      case (idx)
        IDX_VEC: begin
          nxt_st.vbase = wval[VEC_MSB:VEC_LSB];
        end
        IDX_MASK: begin
          // Only bits implemented in this mode
          nxt_st.mask = (cur_ff.mask & ~valid_m) | (wval[NUM_SLOT-1:0] & valid_m);
        end
        IDX_THR: begin
          nxt_st.thr = wval[PRIO_W-1:0];
        end
        IDX_STS: begin
          nxt_st.halt = wval[BIT_HALT];
          nxt_st.tpend = wval[NUM_TMR-1:0];
        end
        IDX_EOI: begin
          // Slave clears by level, master by type or top in service
          if (slave_mode_i) begin
            for (int i = 0; i < NUM_SLOT; i++) begin
              if (valid_m[i] && (prio_of[i] == wval[PRIO_W-1:0])) begin
                nxt_st.isr[i] = 1'b0;
              end
            end
          end else if (wval[BIT_NONSPECIFIC_SELECT]) begin
            if (top_valid) begin
              nxt_st.isr[top_slot] = 1'b0;
            end
          end else begin
            for (int i = 0; i < NUM_SLOT; i++) begin
              if (valid_m[i] && (MST_TYPE[i] == wval[TYPE_W-1:0])) begin
                nxt_st.isr[i] = 1'b0;
              end
            end
          end
        end
        default: begin
          for (int k = 0; k < NUM_CTL; k++) begin
            if (idx == CTL_IDX[k]) begin
              nxt_st.mask[CTL_SLOT[k]] = wval[CTL_MSK_BIT];
              nxt_st.prio[k] = wval[PRIO_W-1:0];
            end
          end
        end
      endcase
    end
    // Acknowledge by poll read or by the CPU; poll does not fetch a vector
    if (access && !cur_ff.err && !pwrite_i && cur_ff.poll_hit) begin
      ack = 1'b1;
      ack_slot = cur_ff.poll_slot;
      // One acknowledge per poll read
      nxt_st.poll_hit = 1'b0;
    end else if (inta_i && win_valid) begin
      ack = 1'b1;
    end
    if (ack) begin
      nxt_st.isr[ack_slot] = 1'b1;
      nxt_st.req[ack_slot] = 1'b0;
      // Timer pending bits per mode
      if (slave_mode_i) begin
        if (ack_slot == 4'(SLOT_TMR)) begin
          nxt_st.tpend[0] = 1'b0;
        end
        if (ack_slot == 4'(SLOT_T1)) begin
          nxt_st.tpend[1] = 1'b0;
        end
        if (ack_slot == 4'(SLOT_T2)) begin
          nxt_st.tpend[2] = 1'b0;
        end
      end else if (ack_slot == 4'(SLOT_TMR)) begin
        for (int j = 0; j < NUM_TMR; j++) begin
          if (!tmr_done && nxt_st.tpend[j]) begin
            nxt_st.tpend[j] = 1'b0;
            tmr_done = 1'b1;
          end
        end
      end
    end
    // Hardware sets win over clears in the same cycle
    nxt_st.tpend = nxt_st.tpend | timer_req_i;
    nxt_st.req[SLOT_D0] = nxt_st.req[SLOT_D0] | dma_req_i[0];
    nxt_st.req[SLOT_D1] = nxt_st.req[SLOT_D1] | dma_req_i[1];
    nxt_st.req[SLOT_WD] = nxt_st.req[SLOT_WD] | wd_req_i;
    nxt_st.req[SLOT_SP] = nxt_st.req[SLOT_SP] | serial_req_i;
    // DMA halt: nmi beats iret
    if (iret_i) begin
      nxt_st.halt = 1'b0;
    end
    if (nmi_i) begin
      nxt_st.halt = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      cur_ff <= ST_RESET;
    end else begin
      cur_ff <= nxt_st;
    end
  end
endmodule // imp_ctrl
`default_nettype wire

// ### imp_cpu_model.sv
// Event source model for the CPU core and peripheral pulses
`timescale 1ns/10ps
`default_nettype none
module imp_cpu_model (
  // Clock
  input wire logic clk_sys_i,
  // Event request from bench
  input wire logic [7:0] ev_i,
  // One-cycle pulses
  output logic [2:0] timer_req_o,
  output logic [1:0] dma_req_o,
  output logic nmi_o,
  output logic iret_o,
  output logic inta_o
);
  initial {inta_o, iret_o, nmi_o, dma_req_o, timer_req_o} = 8'h0;
  // Pulses launched on the edge after a request
  always @(posedge clk_sys_i) begin
    {inta_o, iret_o, nmi_o, dma_req_o, timer_req_o} <= ev_i;
  end
endmodule // imp_cpu_model
`default_nettype wire

// ### imp_ctrl_chk.sv
// Assertions on the controller ports
`timescale 1ns/10ps
`default_nettype none
module imp_ctrl_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // Bus
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [imp_pkg::APB_AW-1:0] paddr_i,
  input wire logic [imp_pkg::DATA_W-1:0] prdata_o,
  input wire logic pslverr_o,
  // Mode and events
  input wire logic slave_mode_i,
  input wire logic nmi_i,
  input wire logic iret_i,
  input wire logic int_req_o,
  input wire logic [7:0] int_type_o,
  input wire logic dma_halt_o
);
  logic rd_acc;
  assign rd_acc = psel_i && penable_i && !pwrite_i;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  property p_eoi_rd;
    rd_acc && paddr_i == 8'h88 |-> prdata_o == 32'h0 && !pslverr_o;
  endproperty
  a_eoi_rd: assert property (p_eoi_rd) else $error("eoi read not zero");
  property p_poll_rsv;
    rd_acc && (paddr_i == 8'h90 || paddr_i == 8'h98) && !slave_mode_i
      |-> prdata_o[14:5] == 10'h0 && prdata_o[31:16] == 16'h0;
  endproperty
  a_poll_rsv: assert property (p_poll_rsv) else $error("poll reserved bits");
  property p_slv_poll;
    rd_acc && paddr_i == 8'h90 && slave_mode_i && $past(slave_mode_i) |-> pslverr_o;
  endproperty
  a_slv_poll: assert property (p_slv_poll) else $error("slave poll accepted");
  property p_mst_t1;
    psel_i && penable_i && paddr_i == 8'he0 && !slave_mode_i && !$past(slave_mode_i)
      |-> pslverr_o && prdata_o == 32'h0;
  endproperty
  a_mst_t1: assert property (p_mst_t1) else $error("master timer1 word mapped");
  property p_mst_type;
    !slave_mode_i && !$past(slave_mode_i) && !$past(slave_mode_i, 2) && int_req_o
      |-> int_type_o[7:5] == 3'h0;
  endproperty
  a_mst_type: assert property (p_mst_type) else $error("master type high bits");
  property p_slv_low;
    slave_mode_i && $past(slave_mode_i) && $past(slave_mode_i, 2) && int_req_o
      |-> int_type_o[2:0] inside {3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
  endproperty
  a_slv_low: assert property (p_slv_low) else $error("slave low type bits");
  property p_halt_set;
    nmi_i |=> dma_halt_o ##1 (dma_halt_o || $past(iret_i) ||
      $past(psel_i && penable_i && pwrite_i));
  endproperty
  a_halt_set: assert property (p_halt_set) else $error("halt not set");
  property p_halt_clr;
    iret_i && !nmi_i |=> !dma_halt_o;
  endproperty
  a_halt_clr: assert property (p_halt_clr) else $error("halt not cleared");
  property p_halt_hold;
    !nmi_i && !iret_i && !(psel_i && penable_i && pwrite_i) |=> $stable(dma_halt_o);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt changed alone");
endmodule // imp_ctrl_chk
bind imp_ctrl imp_ctrl_chk i_imp_ctrl_chk (.clk_sys_i, .nrst_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .prdata_o, .pslverr_o, .slave_mode_i, .nmi_i, .iret_i, .int_req_o,
  .int_type_o, .dma_halt_o);
`default_nettype wire

// ### imp_ctrl_tb.sv
// Self-checking bench for the controller registers
`timescale 1ns/10ps
`default_nettype none
module imp_ctrl_tb;
  import imp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic slv = 1'b0;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] ev = 8'h0;
  logic [4:0] ext = 5'h0;
  logic wdg = 1'b0;
  logic ser = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, int_req, halt, inta, nmi, iret;
  logic [7:0] int_type;
  logic [2:0] tmr;
  logic [1:0] dma;
  logic [32:0] exp_q[$];
  logic [32:0] msk_q[$];
  int n_mismatch = 0;
  int n_checks = 0;
  int seed = 2803;
  logic [15:0] v;
  always #10 clk_sys_i = ~clk_sys_i;
  imp_cpu_model i_imp_cpu_model (.clk_sys_i, .ev_i(ev), .timer_req_o(tmr), .dma_req_o(dma),
    .nmi_o(nmi), .iret_o(iret), .inta_o(inta));
  imp_ctrl i_imp_ctrl (.clk_sys_i, .nrst_i, .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .slave_mode_i(slv), .timer_req_i(tmr), .dma_req_i(dma),
    .ext_int_i(ext), .wd_req_i(wdg), .serial_req_i(ser), .nmi_i(nmi), .iret_i(iret),
    .inta_i(inta), .int_req_o(int_req), .int_type_o(int_type), .dma_halt_o(halt));
  task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] g,
      input logic [32:0] m);
    n_checks++;
    if ((g & m) !== (e & m)) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e & m, g & m);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      close_out();
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e,
      input logic [32:0] m = {33{1'b1}});
    exp_q.push_back(e);
    msk_q.push_back(m);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input logic [7:0] e);
    ev <= e;
    @(posedge clk_sys_i);
    ev <= 8'h0;
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic wait_req();
    int n;
    for (n = 0; n < 20 && int_req !== 1'b1; n++) @(posedge clk_sys_i);
    if (n >= 20) begin
      n_mismatch++;
      close_out();
    end
  endtask
  // Read data checked against the oldest note
  always @(posedge clk_sys_i) begin
    if (psel && pen && pready === 1'b1 && !pwr && exp_q.size() > 0) begin
      cmp($sformatf("read %h", paddr), exp_q.pop_front(), {pslverr, prdata}, msk_q.pop_front());
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    @(posedge clk_sys_i);
    rd(8'ha0, {17'h0, RST_MASK});
    rd(8'ha8, 33'h7);
    rd(8'hc0, 33'h0);
    rd(8'hc8, 33'hf);
    rd(8'hd0, 33'hf);
    rd(8'hd8, 33'hf);
    rd(8'he0, 33'h1_0000_0000);
    rd(8'h88, 33'h0);
    $display("test reset values done");
    v = 16'($random(seed));
    xfer(1'b1, 8'ha0, {16'h0, v});
    rd(8'ha0, {17'h0, v & RST_MASK});
    rd(8'hc8, {29'h0, v[0], 3'h7});
    rd(8'hd0, {29'h0, v[2], 3'h7});
    rd(8'hd8, {29'h0, v[3], 3'h7});
    xfer(1'b1, 8'ha0, 32'h07f0);
    pulse(8'h09);
    rd(8'h98, 33'h8008);
    rd(8'h98, 33'h8008);
    rd(8'h90, 33'h8008);
    rd(8'hb0, 33'h1);
    rd(8'hb8, 33'h4);
    xfer(1'b1, 8'h88, 32'h8);
    rd(8'h90, 33'h800a);
    rd(8'hb0, 33'h4);
    xfer(1'b1, 8'h88, 32'h8000);
    rd(8'hb0, 33'h0);
    ext <= 5'h11;
    wdg <= 1'b1;
    ser <= 1'b1;
    @(posedge clk_sys_i);
    wdg <= 1'b0;
    ser <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    rd(8'hb8, 33'h710);
    $display("test master poll done");
    slv <= 1'b1;
    @(posedge clk_sys_i);
    rd(8'h90, 33'h1_0000_0000);
    xfer(1'b1, 8'he0, 32'h2);
    rd(8'he0, 33'h2);
    xfer(1'b1, 8'he8, 32'hd);
    rd(8'he8, 33'hd);
    rd(8'ha0, 33'h20);
    xfer(1'b1, 8'h80, 32'ha8);
    rd(8'h80, 33'ha8);
    pulse(8'h02);
    wait_req();
    cmp("type", 33'hac, {25'h0, int_type}, 33'hff);
    rd(8'hb8, 33'h10);
    pulse(8'h80);
    rd(8'hb0, 33'h10);
    pulse(8'h01);
    cmp("nest", 33'h0, {32'h0, int_req}, 33'h1);
    xfer(1'b1, 8'h88, 32'h2);
    rd(8'hb0, 33'h0);
    wait_req();
    cmp("type", 33'ha8, {25'h0, int_type}, 33'hff);
    xfer(1'b1, 8'ha8, 32'h6);
    repeat (3) @(posedge clk_sys_i);
    cmp("thr", 33'h0, {32'h0, int_req}, 33'h1);
    pulse(8'h20);
    cmp("halt", 33'h1, {32'h0, halt}, 33'h1);
    rd(8'hc0, 33'h8000, 33'h8000);
    pulse(8'h40);
    cmp("halt", 33'h0, {32'h0, halt}, 33'h1);
    rd(8'hc0, 33'h0, 33'h8000);
    $display("test slave mode done");
    close_out();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    close_out();
  end
endmodule // imp_ctrl_tb
`default_nettype wire
